/* File: boot_pkg.sv */
package boot_pkg;
	typedef enum logic [1:0] {
		PATH_EXT_EXEC   = 2'b00,
		PATH_PAR_FLASH  = 2'b01,
		PATH_SPI_SLAVE  = 2'b10,
		PATH_SPI_MEMORY = 2'b11
	} boot_path_e;

	typedef enum logic [1:0] {
		ST_CAPTURE = 2'b00,
		ST_HEADER  = 2'b01,
		ST_DATA    = 2'b10,
		ST_RUN     = 2'b11
	} load_state_e;

	typedef enum logic [1:0] {
		SP_IDLE   = 2'b00,
		SP_CMD    = 2'b01,
		SP_ZERO   = 2'b10,
		SP_STREAM = 2'b11
	} spi_state_e;

	typedef struct packed {
		logic [1:0] hold;
		logic [3:0] access;
		logic [2:0] setup;
		logic       pack16;
		logic [1:0] bank;
	} mem_cfg_s;

	// First byte of a header lands in the low byte of addr
	typedef struct packed {
		logic [15:0] flag;
		logic [31:0] count;
		logic [31:0] addr;
	} block_hdr_s;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} stream_byte_s;

	localparam logic [31:0] EXT_EXEC_ADDR  = 32'h2000_0000;
	localparam logic [1:0]  SLOW_HOLD      = 2'h3;
	localparam logic [3:0]  SLOW_ACCESS    = 4'hF;
	localparam logic [2:0]  SLOW_SETUP     = 3'h4;
	localparam logic [1:0]  BANK_ZERO      = 2'h0;
	localparam logic [4:0]  FLASH_CYCLES   = 5'(SLOW_SETUP) + 5'(SLOW_ACCESS) + 5'(SLOW_HOLD);
	localparam logic [3:0]  HDR_LAST       = 4'h9;
	localparam int          FLAG_FINAL_BIT = 15;
	localparam int          HOLD_PIN_LSB   = 5;
	localparam int          HOLD_PIN_MSB   = 10;
	localparam int          SKIP_BOOT_BIT  = 4;
	localparam logic [7:0]  SPI_READ_CMD   = 8'h03;
	localparam logic [7:0]  SPI_ZERO_BYTE  = 8'h00;
	localparam logic [7:0]  SPI_IDLE_BYTE  = 8'hFF;
	localparam logic [2:0]  SPI_MAX_ZEROS  = 3'h4;
	localparam logic [1:0]  CAPTURE_WAIT   = 2'h3;
endpackage : boot_pkg

/* File: reset_boot_loader.sv */
// Functional notes
// - Boot path select 00 runs external memory, 01 loads parallel flash, 10 loads from an SPI host, 11 from serial memory.
// - The boot path pins are captured after power-on reset and after each software reset without the skip bit, and pick the start path.
// - Direct external mode skips loading and starts fetching at 0x2000_0000 with 16-bit packing.
// - Both external memory paths program the slowest timing: 3 hold, 15 access and 4 setup cycles.
// - Parallel flash is read through asynchronous memory bank zero.
// - Serial memory mode drives one dedicated select pin for a single serial memory.
// - Serial memory mode sends a read command then zero address bytes until the address width is found.
// - After the width is found, serial data is shifted in and stored from the block destination onward.
// - In host mode this block is the SPI slave receiving the image bytes from the host master.
// - While busy with a byte the block raises host hold-off and the host waits until it drops.
// - The hold-off pin is chosen by flag bits 10 to 5 of the block header.
// - Every loading path first reads a 10-byte header holding destination address and byte count.
// - Any number of blocks may follow; after the final one execution starts at the start of instruction memory.
// - A software reset with the skip bit set jumps straight to the start of instruction memory.
module reset_boot_loader
	import boot_pkg::*;
#(
	parameter logic [31:0] L1_START         = 32'h0000_0000,
	parameter int          SPI_HALF         = 4,
	parameter logic [5:0]  DEFAULT_HOLD_PIN = 6'h00
) (
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic [1:0]  boot_path_select,
	input  wire logic        soft_reset_req,
	input  wire logic [7:0]  reset_config,
	output mem_cfg_s         mem_cfg,
	output logic      [23:0] flash_addr,
	output logic             flash_rd_n,
	output logic             flash_bank0_sel_n,
	input  wire logic [7:0]  flash_data,
	output logic             spi_sclk,
	output logic             spi_mosi,
	input  wire logic        spi_miso,
	output logic             serial_memory_select_pin_n,
	output logic      [1:0]  spi_addr_bytes,
	input  wire logic        slave_sclk,
	input  wire logic        slave_cs_n,
	input  wire logic        slave_mosi,
	output logic             host_hold_off,
	output logic      [63:0] gpio_hold,
	output logic             imem_we,
	output logic      [31:0] imem_addr,
	output logic      [7:0]  imem_wdata,
	output logic             core_run,
	output logic      [31:0] core_start_addr
);
	function automatic logic [63:0] pin_onehot(input logic [5:0] idx);
		pin_onehot = 64'h0000_0000_0000_0001 << idx;
	endfunction : pin_onehot

	load_state_e  st_q;
	boot_path_e   path_q;
	spi_state_e   sp_q;
	block_hdr_s   hdr_q;
	block_hdr_s   hdr_d;
	stream_byte_s src;
	logic [1:0]  bp_s1_q, bp_s2_q;
	logic [7:0]  fd_s1_q, fd_s2_q;
	logic        miso_s1_q, miso_s2_q;
	logic [1:0]  cap_cnt_q;
	logic [3:0]  hdr_idx_q;
	logic [31:0] dst_q, rem_q;
	logic        final_q;
	logic [5:0]  hold_pin_q;
	logic        need_byte;

	// Boot path pins are external: two flops before anything looks at them
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			bp_s1_q   <= 2'h0;
			bp_s2_q   <= 2'h0;
			fd_s1_q   <= 8'h00;
			fd_s2_q   <= 8'h00;
			miso_s1_q <= 1'b1;
			miso_s2_q <= 1'b1;
		end else begin
			bp_s1_q   <= boot_path_select;
			bp_s2_q   <= bp_s1_q;
			fd_s1_q   <= flash_data;
			fd_s2_q   <= fd_s1_q;
			miso_s1_q <= spi_miso;
			miso_s2_q <= miso_s1_q;
		end
	end

	assign need_byte = (st_q == ST_HEADER || st_q == ST_DATA) && !soft_reset_req;

	always_comb begin
		hdr_d = hdr_q;
		hdr_d[hdr_idx_q * 8 +: 8] = src.data;
	end

	// Loader sequencer
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q            <= ST_CAPTURE;
			path_q          <= PATH_EXT_EXEC;
			cap_cnt_q       <= 2'h0;
			hdr_idx_q       <= 4'h0;
			hdr_q           <= '0;
			dst_q           <= 32'h0000_0000;
			rem_q           <= 32'h0000_0000;
			final_q         <= 1'b0;
			hold_pin_q      <= DEFAULT_HOLD_PIN;
			mem_cfg         <= '0;
			imem_we         <= 1'b0;
			imem_addr       <= 32'h0000_0000;
			imem_wdata      <= 8'h00;
			core_run        <= 1'b0;
			core_start_addr <= 32'h0000_0000;
		end else begin
			imem_we <= 1'b0;
			if (soft_reset_req) begin
				core_run <= 1'b0;
				if (reset_config[SKIP_BOOT_BIT]) begin
					st_q            <= ST_RUN;
					core_run        <= 1'b1;
					core_start_addr <= L1_START;
				end else begin
					st_q      <= ST_CAPTURE;
					cap_cnt_q <= 2'h0;
				end
			end else begin
				case (st_q)
					ST_CAPTURE: begin
						cap_cnt_q <= cap_cnt_q + 2'h1;
						if (cap_cnt_q == CAPTURE_WAIT) begin
							path_q    <= boot_path_e'(bp_s2_q);
							hdr_idx_q <= 4'h0;
							final_q   <= 1'b0;
							mem_cfg   <= '0;
							if (bp_s2_q == PATH_EXT_EXEC || bp_s2_q == PATH_PAR_FLASH) begin
								mem_cfg.hold   <= SLOW_HOLD;
								mem_cfg.access <= SLOW_ACCESS;
								mem_cfg.setup  <= SLOW_SETUP;
								mem_cfg.bank   <= BANK_ZERO;
							end
							if (bp_s2_q == PATH_EXT_EXEC) begin
								st_q            <= ST_RUN;
								core_run        <= 1'b1;
								core_start_addr <= EXT_EXEC_ADDR;
								mem_cfg.pack16  <= 1'b1;
							end else begin
								st_q <= ST_HEADER;
							end
						end
					end
					ST_HEADER: begin
						if (src.valid) begin
							hdr_q     <= hdr_d;
							hdr_idx_q <= hdr_idx_q + 4'h1;
							if (hdr_idx_q == HDR_LAST) begin
								hdr_idx_q <= 4'h0;
								final_q   <= hdr_d.flag[FLAG_FINAL_BIT];
								dst_q     <= hdr_d.addr;
								rem_q     <= hdr_d.count;
								hold_pin_q <= hdr_d.flag[HOLD_PIN_MSB:HOLD_PIN_LSB];
								if (hdr_d.count != 32'h0000_0000) begin
									st_q <= ST_DATA;
								end else if (hdr_d.flag[FLAG_FINAL_BIT]) begin
									st_q            <= ST_RUN;
									core_run        <= 1'b1;
									core_start_addr <= L1_START;
								end
							end
						end
					end
					ST_DATA: begin
						if (src.valid) begin
							imem_we    <= 1'b1;
							imem_addr  <= dst_q;
							imem_wdata <= src.data;
							dst_q      <= dst_q + 32'h0000_0001;
							rem_q      <= rem_q - 32'h0000_0001;
							if (rem_q == 32'h0000_0001) begin
								// Core starts a cycle after the last write so it never sees a stale word
								if (final_q) begin
									st_q            <= ST_RUN;
									core_start_addr <= L1_START;
								end else begin
									st_q <= ST_HEADER;
								end
							end
						end
					end
					ST_RUN: begin
						core_run <= 1'b1;
					end
					default: begin
						st_q <= ST_CAPTURE;
					end
				endcase
			end
		end
	end

	// Parallel flash reader: one byte per full slow access
	logic [4:0]   fl_cnt_q;
	logic         fl_busy_q;
	stream_byte_s fl_byte_q;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			fl_cnt_q          <= 5'h00;
			fl_busy_q         <= 1'b0;
			fl_byte_q         <= '0;
			flash_addr        <= 24'h00_0000;
			flash_rd_n        <= 1'b1;
			flash_bank0_sel_n <= 1'b1;
		end else begin
			fl_byte_q.valid <= 1'b0;
			if (soft_reset_req || st_q == ST_CAPTURE) begin
				fl_busy_q         <= 1'b0;
				flash_addr        <= 24'h00_0000;
				flash_rd_n        <= 1'b1;
				flash_bank0_sel_n <= 1'b1;
			end else if (fl_busy_q) begin
				fl_cnt_q <= fl_cnt_q + 5'h01;
				if (fl_cnt_q == FLASH_CYCLES) begin
					fl_busy_q         <= 1'b0;
					flash_rd_n        <= 1'b1;
					flash_bank0_sel_n <= 1'b1;
					flash_addr        <= flash_addr + 24'h00_0001;
					fl_byte_q.valid   <= 1'b1;
					fl_byte_q.data    <= fd_s2_q;
				end
			end else if (need_byte && path_q == PATH_PAR_FLASH && !fl_byte_q.valid) begin
				fl_busy_q         <= 1'b1;
				fl_cnt_q          <= 5'h00;
				flash_rd_n        <= 1'b0;
				flash_bank0_sel_n <= 1'b0;
			end
		end
	end

	// SPI master byte shifter, mode 0, MISO sampled late in the high phase
	logic [7:0]   sh_tx_q, sh_rx_q;
	logic [2:0]   sh_bit_q;
	logic         sh_busy_q, sh_done_q;
	logic [7:0]   div_q;
	logic         sh_go;
	logic [7:0]   sh_go_byte;
	logic [2:0]   zeros_q;
	stream_byte_s sp_byte_q;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sh_tx_q   <= 8'h00;
			sh_rx_q   <= 8'h00;
			sh_bit_q  <= 3'h0;
			sh_busy_q <= 1'b0;
			sh_done_q <= 1'b0;
			div_q     <= 8'h00;
			spi_sclk  <= 1'b0;
			spi_mosi  <= 1'b0;
		end else begin
			sh_done_q <= 1'b0;
			if (sh_go) begin
				sh_busy_q <= 1'b1;
				sh_tx_q   <= sh_go_byte;
				spi_mosi  <= sh_go_byte[7];
				sh_bit_q  <= 3'h0;
				div_q     <= 8'h00;
			end else if (sh_busy_q) begin
				div_q <= div_q + 8'h01;
				if (div_q == 8'(SPI_HALF - 1)) begin
					div_q    <= 8'h00;
					spi_sclk <= !spi_sclk;
					if (spi_sclk) begin
						sh_rx_q  <= {sh_rx_q[6:0], miso_s2_q};
						sh_tx_q  <= {sh_tx_q[6:0], 1'b0};
						spi_mosi <= sh_tx_q[6];
						sh_bit_q <= sh_bit_q + 3'h1;
						if (sh_bit_q == 3'h7) begin
							sh_busy_q <= 1'b0;
							sh_done_q <= 1'b1;
						end
					end
				end
			end
		end
	end

	// Serial memory sequence: command, zero bytes until data shows, then stream
	always_comb begin
		sh_go      = 1'b0;
		sh_go_byte = SPI_ZERO_BYTE;
		if (!soft_reset_req && path_q == PATH_SPI_MEMORY && !sh_busy_q) begin
			case (sp_q)
				SP_IDLE: begin
					sh_go      = need_byte;
					sh_go_byte = SPI_READ_CMD;
				end
				SP_CMD: sh_go = sh_done_q;
				SP_ZERO: sh_go = sh_done_q && (zeros_q < 3'h2 || (sh_rx_q == SPI_IDLE_BYTE && zeros_q < SPI_MAX_ZEROS));
				SP_STREAM: sh_go = need_byte && !sh_done_q && !sp_byte_q.valid;
				default: sh_go = 1'b0;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sp_q                       <= SP_IDLE;
			zeros_q                    <= 3'h0;
			sp_byte_q                  <= '0;
			spi_addr_bytes             <= 2'h0;
			serial_memory_select_pin_n <= 1'b1;
		end else begin
			sp_byte_q.valid <= 1'b0;
			if (soft_reset_req || st_q == ST_CAPTURE || st_q == ST_RUN) begin
				sp_q                       <= SP_IDLE;
				serial_memory_select_pin_n <= 1'b1;
			end else begin
				case (sp_q)
					SP_IDLE: begin
						if (sh_go) begin
							serial_memory_select_pin_n <= 1'b0;
							sp_q                       <= SP_CMD;
						end
					end
					SP_CMD: begin
						if (sh_done_q) begin
							zeros_q <= 3'h1;
							sp_q    <= SP_ZERO;
						end
					end
					SP_ZERO: begin
						if (sh_done_q) begin
							zeros_q <= zeros_q + 3'h1;
							if (zeros_q >= 3'h2 && (sh_rx_q != SPI_IDLE_BYTE || zeros_q == SPI_MAX_ZEROS)) begin
								spi_addr_bytes <= 2'(zeros_q - 3'h1);
								sp_byte_q      <= '{valid: 1'b1, data: sh_rx_q};
								sp_q           <= SP_STREAM;
							end else if (zeros_q < 3'h2 || sh_rx_q == SPI_IDLE_BYTE) begin
								sp_q <= SP_ZERO;
							end
						end
					end
					SP_STREAM: begin
						if (sh_done_q) begin
							sp_byte_q <= '{valid: 1'b1, data: sh_rx_q};
						end
					end
					default: sp_q <= SP_IDLE;
				endcase
			end
		end
	end

	// SPI slave shifter on the host clock
	logic [7:0] sl_shift_q, sl_byte_q;
	logic [2:0] sl_bit_q;
	logic       sl_tog_q;

	always_ff @(posedge slave_sclk or negedge reset_n) begin
		if (!reset_n) begin
			sl_shift_q <= 8'h00;
			sl_byte_q  <= 8'h00;
			sl_bit_q   <= 3'h0;
			sl_tog_q   <= 1'b0;
		end else if (!slave_cs_n) begin
			sl_shift_q <= {sl_shift_q[6:0], slave_mosi};
			sl_bit_q   <= sl_bit_q + 3'h1;
			if (sl_bit_q == 3'h7) begin
				sl_byte_q <= {sl_shift_q[6:0], slave_mosi};
				sl_tog_q  <= !sl_tog_q;
			end
		end
	end

	// Toggle crossing; the byte register stays still because the host is held off
	logic         tg_s1_q, tg_s2_q, tg_s3_q;
	stream_byte_s sl_sys_q;
	logic         sl_busy_q;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			tg_s1_q       <= 1'b0;
			tg_s2_q       <= 1'b0;
			tg_s3_q       <= 1'b0;
			sl_sys_q      <= '0;
			sl_busy_q     <= 1'b0;
			host_hold_off <= 1'b0;
			gpio_hold     <= 64'h0000_0000_0000_0000;
		end else begin
			tg_s1_q        <= sl_tog_q;
			tg_s2_q        <= tg_s1_q;
			tg_s3_q        <= tg_s2_q;
			sl_sys_q.valid <= 1'b0;
			sl_busy_q      <= sl_sys_q.valid;
			if (tg_s2_q != tg_s3_q && path_q == PATH_SPI_SLAVE && need_byte) begin
				sl_sys_q <= '{valid: 1'b1, data: sl_byte_q};
			end
			// hold the host while busy
			// Path is not latched yet during capture, so the synced pins decide there
			host_hold_off <= (st_q == ST_CAPTURE && bp_s2_q == PATH_SPI_SLAVE) ||
				(path_q == PATH_SPI_SLAVE && st_q != ST_RUN &&
				(tg_s2_q != tg_s3_q || sl_sys_q.valid || sl_busy_q));
			gpio_hold <= host_hold_off ? pin_onehot(hold_pin_q) : 64'h0000_0000_0000_0000;
		end
	end

	always_comb begin
		case (path_q)
			PATH_PAR_FLASH:  src = fl_byte_q;
			PATH_SPI_MEMORY: src = sp_byte_q;
			PATH_SPI_SLAVE:  src = sl_sys_q;
			default:         src = '0;
		endcase
		if (soft_reset_req) begin
			src.valid = 1'b0;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	sequence hdr_done_s;
		st_q == ST_HEADER && src.valid && hdr_idx_q == HDR_LAST;
	endsequence

	sequence cmd_launch_s;
		sp_q == SP_IDLE && sh_go;
	endsequence

	ext_start_a: assert property ($rose(core_run) && path_q == PATH_EXT_EXEC && !$past(soft_reset_req) |->
		core_start_addr == EXT_EXEC_ADDR && mem_cfg.pack16) else $error("direct start address or packing wrong");
	slow_timing_a: assert property ((path_q == PATH_PAR_FLASH || path_q == PATH_EXT_EXEC) && st_q != ST_CAPTURE |->
		mem_cfg.hold == SLOW_HOLD && mem_cfg.access == SLOW_ACCESS && mem_cfg.setup == SLOW_SETUP)
		else $error("external timing not at slowest");
	flash_bank_a: assert property ($fell(flash_rd_n) |-> !flash_bank0_sel_n ##1 !flash_rd_n [*8])
		else $error("flash read not on bank zero or cut short");
	select_clock_a: assert property (spi_sclk |-> !serial_memory_select_pin_n)
		else $error("serial clock without select");
	read_cmd_a: assert property (cmd_launch_s |=> sh_tx_q == SPI_READ_CMD && sp_q == SP_CMD)
		else $error("read command not sent first");
	hold_busy_a: assert property (path_q == PATH_SPI_SLAVE && sl_sys_q.valid && st_q != ST_RUN |=>
		host_hold_off) else $error("host not held while busy");
	hdr_len_a: assert property (st_q == ST_HEADER && src.valid && hdr_idx_q != HDR_LAST && !soft_reset_req |=>
		st_q == ST_HEADER) else $error("header shorter than ten bytes");
	final_run_a: assert property (hdr_done_s ##0 (hdr_d.count == 32'h0000_0000 && hdr_d.flag[FLAG_FINAL_BIT]) |=>
		core_run && core_start_addr == L1_START) else $error("final block did not start execution");
	skip_jump_a: assert property (soft_reset_req && reset_config[SKIP_BOOT_BIT] |=>
		st_q == ST_RUN && core_start_addr == L1_START) else $error("skip bit did not bypass boot");
	run_gate_a: assert property (imem_we |-> !core_run)
		else $error("application running while loading");
endmodule : reset_boot_loader

/* File: boot_partner.sv */
module boot_partner
#(
	parameter logic [183:0] IMAGE = '0,
	parameter int           WIDTH = 2
) (
	input  wire logic        sys_clk,
	input  wire logic [23:0] flash_addr,
	input  wire logic        flash_bank0_sel_n,
	output logic      [7:0]  flash_data,
	input  wire logic        spi_sclk,
	input  wire logic        spi_mosi,
	output logic             spi_miso,
	input  wire logic        serial_memory_select_pin_n,
	output logic      [31:0] head_bytes
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] fl_last = 8'h5A;
	logic       so_last = 1'b0;
	logic [7:0] rx_sh   = 8'h00;
	logic [7:0] tx_byte;
	int         rx_bits = 0;
	int         tx_bits = 0;

	// Erased memory past the image reads all ones
	function automatic logic [7:0] image_byte(input int i);
		if (i >= 0 && i < 23) return IMAGE[8*i +: 8];
		return 8'hFF;
	endfunction : image_byte

	// Released lines toggle so a stale value is never mistaken for data
	always @(posedge sys_clk) begin
		fl_last <= flash_data;
		so_last <= spi_miso;
	end

	assign flash_data = flash_bank0_sel_n ? ~fl_last : image_byte(int'(flash_addr));

	initial head_bytes = 32'h0000_0000;

	always @(negedge serial_memory_select_pin_n) begin
		rx_bits = 0;
		tx_bits = 0;
	end

	always @(posedge spi_sclk) begin
		if (!serial_memory_select_pin_n) begin
			rx_sh = {rx_sh[6:0], spi_mosi};
			rx_bits++;
			if (rx_bits % 8 == 0 && rx_bits <= 32) head_bytes[rx_bits-8 +: 8] = rx_sh;
		end
	end

	// Mode 0: next bit presented on the falling edge
	always @(negedge spi_sclk) begin
		if (!serial_memory_select_pin_n) tx_bits = rx_bits;
	end

	// idle answer until address width met
	assign tx_byte  = (tx_bits / 8 <= WIDTH) ? 8'hFF : image_byte(tx_bits / 8 - WIDTH - 1);
	assign spi_miso = serial_memory_select_pin_n ? ~so_last : tx_byte[7 - tx_bits % 8];
endmodule : boot_partner

/* File: reset_boot_loader_bench.sv */
module reset_boot_loader_bench
	import boot_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [31:0]  L1    = 32'h0001_0000;
	localparam logic [183:0] IMAGE = 184'h77_80A0_0000_0001_0000_0080_3CA5_00A0_0000_0002_0000_0040;
	localparam logic [31:0]  EXP_A [3] = '{32'h0000_0040, 32'h0000_0041, 32'h0000_0080};
	localparam logic [7:0]   EXP_D [3] = '{8'hA5, 8'h3C, 8'h77};

	logic        sys_clk;
	logic        reset_n;
	logic [1:0]  boot_path_select;
	logic        soft_reset_req;
	logic [7:0]  reset_config;
	mem_cfg_s    mem_cfg;
	logic [23:0] flash_addr;
	logic        flash_rd_n;
	logic        flash_bank0_sel_n;
	logic [7:0]  flash_data;
	logic        spi_sclk;
	logic        spi_mosi;
	logic        spi_miso;
	logic        serial_memory_select_pin_n;
	logic [1:0]  spi_addr_bytes;
	logic        slave_sclk;
	logic        slave_cs_n;
	logic        slave_mosi;
	logic        host_hold_off;
	logic [63:0] gpio_hold;
	logic        imem_we;
	logic [31:0] imem_addr;
	logic [7:0]  imem_wdata;
	logic        core_run;
	logic [31:0] core_start_addr;
	logic [31:0] head_bytes;
	logic        watch;
	logic        hold_q;
	logic [31:0] wr_a[$];
	logic [7:0]  wr_d[$];
	int          n_fail   = 0;
	int          n_checks = 0;

	reset_boot_loader #(.L1_START(L1)) u_reset_boot_loader (
		.sys_clk, .reset_n, .boot_path_select, .soft_reset_req, .reset_config, .mem_cfg,
		.flash_addr, .flash_rd_n, .flash_bank0_sel_n, .flash_data, .spi_sclk, .spi_mosi,
		.spi_miso, .serial_memory_select_pin_n, .spi_addr_bytes, .slave_sclk, .slave_cs_n,
		.slave_mosi, .host_hold_off, .gpio_hold, .imem_we, .imem_addr, .imem_wdata,
		.core_run, .core_start_addr
	);

	boot_partner #(.IMAGE(IMAGE), .WIDTH(2)) u_boot_partner (
		.sys_clk, .flash_addr, .flash_bank0_sel_n, .flash_data, .spi_sclk, .spi_mosi,
		.spi_miso, .serial_memory_select_pin_n, .head_bytes
	);

	always #12.5 sys_clk = ~sys_clk;

	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		n_checks++;
		if (exp !== got) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish

	always @(posedge sys_clk) begin
		hold_q <= host_hold_off;
		if (imem_we === 1'b1) begin
			wr_a.push_back(imem_addr);
			wr_d.push_back(imem_wdata);
		end
		if (watch) check("gpio_hold", 64'(hold_q) << 5, gpio_hold);
	end

	task automatic wait_run(input int lim);
		int k;
		k = 0;
		while (core_run !== 1'b1 && k < lim) begin
			@(posedge sys_clk);
			#1;
			k++;
		end
		check("core_run", 1, core_run);
	endtask : wait_run

	task automatic soft_reset(input logic [1:0] path, input logic skip);
		@(posedge sys_clk);
		boot_path_select <= path;
		reset_config     <= {3'h0, skip, 4'h0};
		@(posedge sys_clk);
		soft_reset_req <= 1'b1;
		@(posedge sys_clk);
		soft_reset_req <= 1'b0;
		#1;
	endtask : soft_reset

	task automatic check_writes();
		check("write count", 3, 64'(wr_a.size()));
		for (int i = 0; i < 3 && i < wr_a.size(); i++) begin
			check("imem_addr", EXP_A[i], wr_a[i]);
			check("imem_wdata", EXP_D[i], wr_d[i]);
		end
		wr_a.delete();
		wr_d.delete();
	endtask : check_writes

	// Host never starts a byte while held off, and waits a few cycles after each
	task automatic host_byte(input logic [7:0] b);
		int   k;
		logic h;
		k = 0;
		h = 1'b0;
		// Hold-off rises a cycle after a soft reset lands
		@(posedge sys_clk);
		#1;
		while (host_hold_off !== 1'b0 && k < 400) begin
			@(posedge sys_clk);
			#1;
			k++;
		end
		if (k == 400) n_fail++;
		#7;
		for (int i = 7; i >= 0; i--) begin
			slave_mosi = b[i];
			#24 slave_sclk = 1'b1;
			#24 slave_sclk = 1'b0;
		end
		slave_mosi = ~b[0];
		repeat (8) begin
			@(posedge sys_clk);
			#1;
			h = h | host_hold_off;
		end
		check("host_hold_off", 1, h);
	endtask : host_byte

	initial begin
		#500_000;
		n_fail++;
		tally_and_finish();
	end

	initial begin
		sys_clk          = 1'b0;
		reset_n          = 1'b0;
		boot_path_select = 2'b00;
		soft_reset_req   = 1'b0;
		reset_config     = 8'h00;
		slave_sclk       = 1'b0;
		slave_cs_n       = 1'b1;
		slave_mosi       = 1'b0;
		watch            = 1'b0;
		repeat (12) @(posedge sys_clk);
		reset_n <= 1'b1;
		wait_run(20);
		check("start", 32'h2000_0000, core_start_addr);
		check("pack16", 1, mem_cfg.pack16);
		check("timing", {2'h3, 4'hF, 3'h4}, {mem_cfg.hold, mem_cfg.access, mem_cfg.setup});

		soft_reset(2'b01, 1'b0);
		check("core_run", 0, core_run);
		wait_run(2000);
		check_writes();
		check("start", L1, core_start_addr);
		check("bank", 2'h0, mem_cfg.bank);
		check("timing", {2'h3, 4'hF, 3'h4}, {mem_cfg.hold, mem_cfg.access, mem_cfg.setup});

		soft_reset(2'b11, 1'b0);
		check("core_run", 0, core_run);
		wait_run(4000);
		check("command bytes", 24'h00_0003, head_bytes[23:0]);
		check("address width", 2'h2, spi_addr_bytes);
		check("select", 1, serial_memory_select_pin_n);
		check_writes();

		soft_reset(2'b10, 1'b0);
		slave_cs_n = 1'b0;
		for (int i = 0; i < 23; i++) begin
			host_byte(IMAGE[8*i +: 8]);
			if (i == 10) watch <= 1'b1;
		end
		wait_run(400);
		watch <= 1'b0;
		slave_cs_n = 1'b1;
		check_writes();
		check("start", L1, core_start_addr);

		soft_reset(2'b01, 1'b1);
		check("core_run", 1, core_run);
		check("start", L1, core_start_addr);
		tally_and_finish();
	end
endmodule : reset_boot_loader_bench
